// ==== alu_status_word.sv ====
// alu status word: arithmetic flags, repeat indicator and cpu priority level,
// with a classic wishbone slave for software access.
// assumes the alu, repeat and interrupt logic drive one-cycle update strobes
// synchronous to clk_i; the fourth priority bit is kept in core control outside.
`timescale 1ns/1ns
`default_nettype none
module alu_status_word (
    input  wire  logic                            clk_i,
    input  wire  logic                            rst_i,
    // wishbone slave
    input  wire  logic                            cyc_i,
    input  wire  logic                            stb_i,
    input  wire  logic                            we_i,
    input  wire  logic [3:0]                      sel_i,
    input  wire  logic [7:0]                      adr_i,
    input  wire  logic [31:0]                     dat_i,
    output logic [31:0]                           dat_o,
    output logic                                  ack_o,
    // alu side
    input  wire  alu_status_pkg::alu_req_t        alu_req_i,
    output logic [alu_status_pkg::WORD_W-1:0]     alu_result_o,
    // repeat loop and interrupt logic
    input  wire  logic                            repeat_set_i,
    input  wire  logic                            repeat_clr_i,
    input  wire  logic                            prio_load_i,
    input  wire  logic [alu_status_pkg::PRIO_W-1:0] prio_value_i,
    input  wire  logic                            priority_level_msb_i,
    // status outputs
    output logic [alu_status_pkg::WORD_W-1:0]     alu_status_word_o,
    output logic [alu_status_pkg::LEVEL_W-1:0]    cpu_priority_level_o,
    output logic                                  nesting_disable_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [alu_status_pkg::WORD_W-1:0]  result;
        logic                               half_carry_flag;
        logic [alu_status_pkg::PRIO_W-1:0]  cpu_priority_level;
        logic                               repeat_active_flag;
        logic                               neg;
        logic                               signed_overflow_flag;
        logic                               zero;
        logic                               carry;
        logic                               nesting_disable;
        logic                               ack;
        logic [31:0]                        rdata;
    } state_t;

    state_t state_q;
    state_t state_d;

    alu_status_pkg::alu_flags_t        flags;
    logic [alu_status_pkg::WORD_W-1:0] result;
    logic [alu_status_pkg::WORD_W-1:0] status_word;

    alu_flag_unit u_flags (
        .req_i      (alu_req_i),
        .carry_in_i (state_q.carry),
        .result_o   (result),
        .flags_o    (flags)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // merge a 16-bit write through the two low byte enables
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
        logic [15:0] m;
        m = old_v;
        if (sel[0]) begin
            m[7:0] = new_v[7:0];
        end
        if (sel[1]) begin
            m[15:8] = new_v[15:8];
        end
        return m;
    endfunction : merge16

    always_comb begin
        status_word = '0;
        status_word[alu_status_pkg::HALF_BIT]   = state_q.half_carry_flag;
        status_word[alu_status_pkg::PRIO_MSB:alu_status_pkg::PRIO_LSB] = state_q.cpu_priority_level;
        status_word[alu_status_pkg::REPEAT_BIT] = state_q.repeat_active_flag;
        status_word[alu_status_pkg::NEG_BIT]    = state_q.neg;
        status_word[alu_status_pkg::OVF_BIT]    = state_q.signed_overflow_flag;
        status_word[alu_status_pkg::ZERO_BIT]   = state_q.zero;
        status_word[alu_status_pkg::CARRY_BIT]  = state_q.carry;
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic        wb_hit;
    logic        wb_wr;
    logic [15:0] sw_word;
    logic [15:0] cfg_word;

    always_comb begin
        state_d  = state_q;
        wb_hit   = cyc_i && stb_i && !state_q.ack;
        wb_wr    = wb_hit && we_i;
        sw_word  = merge16(status_word, dat_i, sel_i);
        cfg_word = merge16({state_q.nesting_disable, 15'h0000}, dat_i, sel_i);
        state_d.ack   = wb_hit;
        state_d.rdata = alu_status_pkg::UNMAPPED_RD;

        // software writes go first so hardware events in the same cycle win
        if (wb_wr && adr_i == alu_status_pkg::STATUS_OFS) begin
            state_d.half_carry_flag      = sw_word[alu_status_pkg::HALF_BIT];
            state_d.neg                  = sw_word[alu_status_pkg::NEG_BIT];
            state_d.signed_overflow_flag = sw_word[alu_status_pkg::OVF_BIT];
            state_d.zero                 = sw_word[alu_status_pkg::ZERO_BIT];
            state_d.carry                = sw_word[alu_status_pkg::CARRY_BIT];
            if (!state_q.nesting_disable) begin
                state_d.cpu_priority_level = sw_word[alu_status_pkg::PRIO_MSB:alu_status_pkg::PRIO_LSB];
            end
        end
        if (wb_wr && adr_i == alu_status_pkg::CONFIG_OFS) begin
            state_d.nesting_disable = cfg_word[alu_status_pkg::NEST_DIS_BIT];
        end
        // level register is read-only: writes to it do nothing

        if (wb_hit && !we_i) begin
            case (adr_i)
                alu_status_pkg::STATUS_OFS: state_d.rdata = {16'h0000, status_word};
                alu_status_pkg::CONFIG_OFS: state_d.rdata = {16'h0000, state_q.nesting_disable, 15'h0000};
                alu_status_pkg::LEVEL_OFS:  state_d.rdata = {28'h0000000, cpu_priority_level_o};
                default:                    state_d.rdata = alu_status_pkg::UNMAPPED_RD;
            endcase
        end

        if (alu_req_i.valid) begin
            state_d.result               = result;
            state_d.neg                  = flags.neg;
            state_d.signed_overflow_flag = flags.signed_overflow_flag;
            state_d.zero                 = flags.zero;
            state_d.carry                = flags.carry;
            state_d.half_carry_flag      = flags.half_carry_flag;
        end
        if (repeat_clr_i) begin
            state_d.repeat_active_flag = 1'b0;
        end
        if (repeat_set_i) begin
            state_d.repeat_active_flag = 1'b1;
        end
        if (prio_load_i) begin
            state_d.cpu_priority_level = prio_value_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign dat_o             = state_q.rdata;
    assign ack_o             = state_q.ack;
    assign alu_result_o      = state_q.result;
    assign alu_status_word_o = status_word;
    assign nesting_disable_o = state_q.nesting_disable;
    // level plus eight when msb set
    assign cpu_priority_level_o = {priority_level_msb_i, state_q.cpu_priority_level};

endmodule : alu_status_word
`default_nettype wire

// ==== alu_status_pkg.sv ====
// package for the alu status word block: bit positions, register offsets,
// reset values and the carrier structs shared by the main file and the flag unit.
// assumes a 16-bit status word reached over a 32-bit classic wishbone slave.
package alu_status_pkg;

    // ------------------------------------------------------------------
    // status word bit positions
    // ------------------------------------------------------------------
    localparam int unsigned CARRY_BIT    = 0;
    localparam int unsigned ZERO_BIT     = 1;
    localparam int unsigned OVF_BIT      = 2;
    localparam int unsigned NEG_BIT      = 3;
    localparam int unsigned REPEAT_BIT   = 4;
    localparam int unsigned PRIO_LSB     = 5;
    localparam int unsigned PRIO_MSB     = 7;
    localparam int unsigned HALF_BIT     = 8;
    localparam int unsigned PRIO_W       = 3;
    localparam int unsigned LEVEL_W      = 4;
    localparam int unsigned WORD_W       = 16;
    localparam int unsigned BYTE_W       = 8;
    // half carry taken out of this many low-order bits
    localparam int unsigned HALF_BYTE_POS = 4;
    localparam int unsigned HALF_WORD_POS = 8;
    localparam int unsigned NEST_DIS_BIT  = 15;

    // ------------------------------------------------------------------
    // register map (byte addresses on the bus)
    // ------------------------------------------------------------------
    localparam logic [7:0] STATUS_OFS  = 8'h00;
    localparam logic [7:0] CONFIG_OFS  = 8'h04;
    localparam logic [7:0] LEVEL_OFS   = 8'h08;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [15:0] STATUS_MASK = 16'h01FF;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_ADD,
        OP_SUB,
        OP_PASS
    } alu_op_t;

    typedef struct packed {
        logic                valid;
        logic                byte_mode;
        logic                use_carry;
        alu_op_t             op;
        logic [WORD_W-1:0]   a;
        logic [WORD_W-1:0]   b;
    } alu_req_t;

    typedef struct packed {
        logic half_carry_flag;
        logic neg;
        logic signed_overflow_flag;
        logic zero;
        logic carry;
    } alu_flags_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_t;

endpackage : alu_status_pkg

// ==== alu_flag_unit.sv ====
// combinational adder that produces the result and the five arithmetic flags.
// assumes operands are presented together with the request; result is not registered here.
`timescale 1ns/1ns
`default_nettype none
module alu_flag_unit (
    input  wire  alu_status_pkg::alu_req_t   req_i,
    input  wire  logic                       carry_in_i,
    output logic [alu_status_pkg::WORD_W-1:0] result_o,
    output var alu_status_pkg::alu_flags_t   flags_o
);
    localparam int unsigned W  = alu_status_pkg::WORD_W;
    localparam int unsigned BW = alu_status_pkg::BYTE_W;

    logic [W-1:0] opb;
    logic         cin;
    logic [W:0]   sum;
    logic [W:0]   low_sum;
    logic [alu_status_pkg::HALF_WORD_POS:0] half_sum;
    logic [alu_status_pkg::HALF_BYTE_POS:0] nib_sum;
    logic [BW:0]  byte_sum;

    always_comb begin
        opb = (req_i.op == alu_status_pkg::OP_SUB) ? ~req_i.b : req_i.b;
        if (req_i.op == alu_status_pkg::OP_PASS) begin
            opb = '0;
        end
        // subtract adds the inverted operand plus one, or plus carry_in_i when use_carry is set; borrow then reads as carry clear
        cin = req_i.use_carry ? carry_in_i : (req_i.op == alu_status_pkg::OP_SUB);
        sum = {1'b0, req_i.a} + {1'b0, opb} + {{W{1'b0}}, cin};
        low_sum  = sum;
        byte_sum = {1'b0, req_i.a[BW-1:0]} + {1'b0, opb[BW-1:0]} + {{BW{1'b0}}, cin};
        nib_sum  = {1'b0, req_i.a[alu_status_pkg::HALF_BYTE_POS-1:0]}
                 + {1'b0, opb[alu_status_pkg::HALF_BYTE_POS-1:0]}
                 + {{alu_status_pkg::HALF_BYTE_POS{1'b0}}, cin};
        half_sum = byte_sum;
        result_o = req_i.byte_mode ? {{(W-BW){1'b0}}, byte_sum[BW-1:0]} : low_sum[W-1:0];
        flags_o.half_carry_flag = req_i.byte_mode ? nib_sum[alu_status_pkg::HALF_BYTE_POS]
                                                  : half_sum[alu_status_pkg::HALF_WORD_POS];
        if (req_i.byte_mode) begin
            flags_o.neg   = byte_sum[BW-1];
            flags_o.carry = byte_sum[BW];
            flags_o.zero  = (byte_sum[BW-1:0] == '0);
            flags_o.signed_overflow_flag = (req_i.a[BW-1] == opb[BW-1]) && (byte_sum[BW-1] != req_i.a[BW-1]);
        end else begin
            flags_o.neg   = sum[W-1];
            flags_o.carry = sum[W];
            flags_o.zero  = (sum[W-1:0] == '0);
            flags_o.signed_overflow_flag = (req_i.a[W-1] == opb[W-1]) && (sum[W-1] != req_i.a[W-1]);
        end
    end
endmodule : alu_flag_unit
`default_nettype wire

// ==== alu_status_chk.sv ====
// concurrent checks on the ports of the alu status word block
// assumes one clock domain; bound onto every alu_status_word instance
`timescale 1ns/1ns
`default_nettype none
module alu_status_chk (
    input wire logic                     clk_i,
    input wire logic                     rst_i,
    input wire logic                     cyc_i,
    input wire logic                     stb_i,
    input wire logic                     we_i,
    input wire logic [3:0]               sel_i,
    input wire logic [7:0]               adr_i,
    input wire logic [31:0]              dat_i,
    input wire logic                     ack_o,
    input wire alu_status_pkg::alu_req_t alu_req_i,
    input wire logic [15:0]              alu_result_o,
    input wire logic                     prio_load_i,
    input wire logic                     priority_level_msb_i,
    input wire logic [15:0]              alu_status_word_o,
    input wire logic [3:0]               cpu_priority_level_o,
    input wire logic                     nesting_disable_o
);
    // --------------------
    // expected flag sources
    // --------------------
    wire logic [16:0] sum_w = {1'b0, alu_req_i.a} + {1'b0, alu_req_i.b};
    wire logic [8:0]  low_w = {1'b0, alu_req_i.a[7:0]} + {1'b0, alu_req_i.b[7:0]};
    wire logic [4:0]  nib_w = {1'b0, alu_req_i.a[3:0]} + {1'b0, alu_req_i.b[3:0]};
    wire logic add_w = alu_req_i.valid && alu_req_i.op == alu_status_pkg::OP_ADD && !alu_req_i.use_carry;
    wire logic wrd_w = add_w && !alu_req_i.byte_mode;
    // hardware updates win, so software writes are only judged when none is present
    // judged at the edge that takes the write, so the field is compared against its value before it
    wire logic wr_w = cyc_i && stb_i && we_i && !ack_o && adr_i == alu_status_pkg::STATUS_OFS && sel_i[0]
                      && !prio_load_i && !alu_req_i.valid;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_one_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not answered");
    level_join_a: assert property (cpu_priority_level_o == {priority_level_msb_i, alu_status_word_o[7:5]})
        else $error("level not field plus fourth bit");
    half_word_a: assert property (wrd_w |=> alu_status_word_o[8] == $past(low_w[8]))
        else $error("word half carry wrong");
    half_byte_a: assert property (add_w && alu_req_i.byte_mode |=> alu_status_word_o[8] == $past(nib_w[4]))
        else $error("byte half carry wrong");
    add_flags_a: assert property (wrd_w |=> alu_status_word_o[0] == $past(sum_w[16])
        && alu_status_word_o[1] == (alu_result_o == 16'h0000) && alu_status_word_o[3] == alu_result_o[15])
        else $error("carry zero or sign flag wrong");
    nest_lock_a: assert property (wr_w && nesting_disable_o |=> $stable(alu_status_word_o[7:5]))
        else $error("locked priority field changed");
    prio_write_a: assert property (wr_w && !nesting_disable_o |=> alu_status_word_o[7:5] == $past(dat_i[7:5]))
        else $error("priority write not applied");
    upper_zero_a: assert property (alu_status_word_o[15:9] == 7'h00)
        else $error("unused status bits set");

    cover property (wr_w && nesting_disable_o);
    cover property (add_w && alu_req_i.byte_mode);
    cover property (prio_load_i);
endmodule : alu_status_chk

bind alu_status_word alu_status_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o), .alu_req_i(alu_req_i),
    .alu_result_o(alu_result_o), .prio_load_i(prio_load_i), .priority_level_msb_i(priority_level_msb_i),
    .alu_status_word_o(alu_status_word_o), .cpu_priority_level_o(cpu_priority_level_o),
    .nesting_disable_o(nesting_disable_o));
`default_nettype wire

// ==== alu_side_model.sv ====
// far side model: alu operand source plus repeat and priority load pulses
// assumes the bench calls one task at a time; pins change right after clk_i rises
`timescale 1ns/1ns
`default_nettype none
module alu_side_model (
    input  wire logic                clk_i,
    output var alu_status_pkg::alu_req_t req_o,
    output logic [2:0]               hw_o,
    output logic [2:0]               pv_o
);
    initial begin
        req_o = '0;
        hw_o = 3'h0;
        pv_o = 3'h0;
    end
    // --------------------
    // one-cycle pulses
    // --------------------
    task automatic op(input logic bm, input logic uc, input alu_status_pkg::alu_op_t o,
                      input logic [15:0] a, input logic [15:0] b);
        @(posedge clk_i);
        req_o <= '{1'b1, bm, uc, o, a, b};
        @(posedge clk_i);
        // stale operands are scrambled so a late sample cannot match
        req_o <= '{1'b0, bm, uc, o, ~a, ~b};
    endtask : op
    task automatic pulse(input logic [2:0] k, input logic [2:0] v);
        @(posedge clk_i);
        hw_o <= k;
        pv_o <= v;
        @(posedge clk_i);
        hw_o <= 3'h0;
        pv_o <= ~v;
    endtask : pulse
endmodule : alu_side_model
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the alu status word and its far side model
// assumes package, design, checker and model are compiled before it
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam logic [7:0] ST = alu_status_pkg::STATUS_OFS;
    localparam logic [7:0] CF = alu_status_pkg::CONFIG_OFS;
    localparam logic [7:0] LV = alu_status_pkg::LEVEL_OFS;
    localparam alu_status_pkg::alu_op_t ADD = alu_status_pkg::OP_ADD;
    localparam alu_status_pkg::alu_op_t SUB = alu_status_pkg::OP_SUB;
    localparam alu_status_pkg::alu_op_t PAS = alu_status_pkg::OP_PASS;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, msb = 1'b0, ack, nd;
    logic [3:0] sel = 4'h0, lvl;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat, r;
    logic [15:0] res, sw;
    logic [2:0] hw, pv;
    alu_status_pkg::alu_req_t req;
    int fail_count = 0;
    int compares = 0;

    always #2 clk_i = ~clk_i;
    alu_side_model mdl_u (.clk_i(clk_i), .req_o(req), .hw_o(hw), .pv_o(pv));
    alu_status_word dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(sel),
        .adr_i(adr), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .alu_req_i(req), .alu_result_o(res),
        .repeat_set_i(hw[0]), .repeat_clr_i(hw[1]), .prio_load_i(hw[2]), .prio_value_i(pv),
        .priority_level_msb_i(msb), .alu_status_word_o(sw), .cpu_priority_level_o(lvl),
        .nesting_disable_o(nd));
    // --------------------
    // shared tasks
    // --------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, sel, adr, dat} <= {2'b11, w, 4'h3, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) fail_count++;
        r = rdat;
        {cyc, stb} <= 2'b00;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(r, e);
    endtask : rd
    task automatic sw_is(input logic [31:0] e);
        @(posedge clk_i);
        chk({16'h0, sw}, e);
    endtask : sw_is
    task automatic alu(input logic bm, input logic uc, input alu_status_pkg::alu_op_t o, input logic [15:0] a,
                       input logic [15:0] b, input logic [31:0] er, input logic [31:0] es);
        mdl_u.op(bm, uc, o, a, b);
        @(posedge clk_i);
        chk(bm ? {24'h0, res[7:0]} : {16'h0, res}, er);
        chk({16'h0, sw}, es);
    endtask : alu
    task automatic t_alu();
        alu(0, 0, ADD, 16'hFFFF, 16'h0001, 32'h0, 32'h0103);
        alu(0, 1, ADD, 16'h0000, 16'h0000, 32'h1, 32'h0000);
        alu(0, 0, ADD, 16'h7FFF, 16'h0001, 32'h8000, 32'h010C);
        alu(1, 0, ADD, 16'h000F, 16'h0001, 32'h10, 32'h0100);
        alu(1, 0, ADD, 16'h0080, 16'h0080, 32'h0, 32'h0007);
        alu(0, 0, SUB, 16'h0005, 16'h0005, 32'h0, 32'h0103);
        alu(0, 0, SUB, 16'h0000, 16'h0001, 32'hFFFF, 32'h0008);
        alu(0, 0, PAS, 16'h8000, 16'h1234, 32'h8000, 32'h0008);
    endtask : t_alu
    task automatic t_soft();
        wb(1, ST, 32'h01FF);
        rd(ST, 32'h01EF);
        wb(1, ST, 32'h0040);
        @(posedge clk_i);
        chk({28'h0, lvl}, 32'h2);
        msb <= 1'b1;
        rd(LV, 32'hA);
        wb(1, LV, 32'h0);
        rd(LV, 32'hA);
        msb <= 1'b0;
    endtask : t_soft
    task automatic t_nest();
        wb(1, CF, 32'h8000);
        rd(CF, 32'h8000);
        chk({31'h0, nd}, 32'h1);
        wb(1, ST, 32'h0000);
        rd(ST, 32'h0040);
        mdl_u.pulse(3'h4, 3'h5);
        sw_is(32'h00A0);
        wb(1, CF, 32'h0);
        wb(1, ST, 32'h0020);
        rd(ST, 32'h0020);
    endtask : t_nest
    task automatic t_misc();
        mdl_u.pulse(3'h1, 3'h0);
        sw_is(32'h0030);
        wb(1, ST, 32'h0020);
        rd(ST, 32'h0030);
        mdl_u.pulse(3'h2, 3'h0);
        sw_is(32'h0020);
        // set and clear in one cycle: set wins
        mdl_u.pulse(3'h3, 3'h0);
        sw_is(32'h0030);
        wb(1, 8'h0C, 32'h1234);
        rd(8'h0C, 32'h0);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        sw_is(32'h0);
    endtask : t_misc
    task automatic summarize();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        sw_is(32'h0);
        t_alu();
        t_soft();
        t_nest();
        t_misc();
        summarize();
    end
    // the whole run needs about a hundred cycles; this leaves ample slack
    initial begin
        #20000;
        fail_count++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
